//--- fdsc_top.sv
// Overview of operation
// - Scaling code in bits 7:5 divides by 64 down to 1, code 111 doubles.
// - Each filter sample is multiplied by the unsigned 5-bit value, 0 to 31.
// - Filter divider is 11 bits; its low byte sits in the low-byte register.
// - Divider top three bits come from the upper config register, above the low byte.
// - Chip one gives positive deviation, zero negative; inversion swaps the directions.
// - Deviation is signed about the centre, so tone spacing is twice the deviation.
// - Bypass bit clear shapes, set passes plain FSK; ASK mode always bypasses.
//
// The strobed register port is this design's own decision.
module fdsc_top
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire fdsc_pkg::fdsc_bus_s bus_req,
	output logic [7:0] rdata,
	// Encoded chip stream
	input wire logic chip_data,
	// Filter timing
	output logic sample_tick,
	output logic [fdsc_pkg::FDSC_DIV_W-1:0] active_divider,
	// Modulation output
	output logic signed [fdsc_pkg::FDSC_DEV_W-1:0] deviation,
	output logic deviation_vld
);
	import fdsc_pkg::*;

	typedef struct packed
	{
		fdsc_state_e st;
		logic [7:0] dev_reg;
		logic [7:0] div_lo;
		logic [7:0] upper;
		logic [7:0] ctrl;
		fdsc_dev_s act_dev;
		logic [FDSC_DIV_W-1:0] act_div;
		logic act_bypass;
		logic act_inv;
		logic [FDSC_DIV_W-1:0] cnt;
		logic tick;
		logic [FDSC_HIST_W-1:0] hist;
		logic signed [FDSC_SAMPLE_W-1:0] sample;
		fdsc_dev_s sample_dev;
		logic sample_vld;
		logic [7:0] rdata;
	} fdsc_core_s;

	fdsc_core_s s;
	fdsc_core_s next_s;
	logic pol;
	logic [FDSC_HIST_W-1:0] new_hist;
	logic signed [FDSC_SAMPLE_W-1:0] acc;
	logic signed [FDSC_SAMPLE_W-1:0] term [FDSC_HIST_W];
	logic [FDSC_DIV_W-1:0] prog_div;
	logic prog_bypass;

	// Programmed divider, upper bits above low byte
	// concatenate upper bits
	assign prog_div = {s.upper[FDSC_UPPER_LSB +: FDSC_UPPER_W], s.div_lo};
	assign prog_bypass = s.upper[FDSC_BYPASS_BIT] | s.ctrl[FDSC_CTRL_ASK_BIT];

	// Chip polarity toward positive deviation
	// inversion swaps direction
	assign pol = chip_data ^ s.act_inv;
	assign new_hist = {s.hist[FDSC_HIST_W-2:0], pol};

	// Signed weight of each tap, positive for a one chip
	for (genvar g = 0; g < FDSC_HIST_W; g++)
	begin : g_tap
		logic signed [FDSC_SAMPLE_W-1:0] weight;
		assign weight = FDSC_SAMPLE_W'(FDSC_TAPS[4*g +: 4]);
		assign term[g] = new_hist[g] ? weight : -weight;
	end

	// Shaping filter, weighted sum of recent chips
	always_comb
	begin
		acc = '0;
		for (int i = 0; i < FDSC_HIST_W; i++)
			acc = acc + term[i];
	end

	// Next state of the whole block
	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.sample_vld = 1'b0;
		next_s.rdata = '0;

		// Register writes
		if (bus_req.wr)
		begin
			case (bus_req.addr)
				FDSC_OFS_DEV: next_s.dev_reg = bus_req.wdata;
				FDSC_OFS_DIV_LO: next_s.div_lo = bus_req.wdata;
				FDSC_OFS_UPPER: next_s.upper = bus_req.wdata;
				FDSC_OFS_CTRL: next_s.ctrl = bus_req.wdata;
				default: next_s.ctrl = s.ctrl;
			endcase
		end

		// Register reads, data in the next cycle only
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				FDSC_OFS_DEV: next_s.rdata = s.dev_reg;
				FDSC_OFS_DIV_LO: next_s.rdata = s.div_lo;
				FDSC_OFS_UPPER: next_s.rdata = s.upper;
				FDSC_OFS_CTRL: next_s.rdata = s.ctrl;
				FDSC_OFS_STATUS:
				begin
					next_s.rdata[FDSC_STAT_RUN_BIT] = (s.st == FDSC_RUN);
					next_s.rdata[FDSC_STAT_BYP_BIT] = s.act_bypass;
					next_s.rdata[FDSC_STAT_INV_BIT] = s.act_inv;
				end
				default: next_s.rdata = '0;
			endcase
		end

		// Sample divider and setting hand-over
		case (s.st)
			FDSC_IDLE:
			begin
				next_s.cnt = '0;
				if (s.ctrl[FDSC_CTRL_EN_BIT])
					next_s.st = FDSC_RUN;
			end
			FDSC_RUN:
			begin
				if (!s.ctrl[FDSC_CTRL_EN_BIT])
					next_s.st = FDSC_IDLE;
				else if (s.cnt == '0)
				begin
					next_s.tick = 1'b1;
					next_s.act_dev = fdsc_dev_s'(s.dev_reg);
					next_s.act_div = prog_div;
					next_s.act_bypass = prog_bypass;
					next_s.act_inv = s.ctrl[FDSC_CTRL_INV_BIT];
					next_s.cnt = prog_div;
				end
				else
					next_s.cnt = s.cnt - 1'b1;
			end
			default: next_s.st = FDSC_IDLE;
		endcase

		// One filter step per boundary
		if (s.tick)
		begin
			next_s.hist = new_hist;
			next_s.sample_dev = s.act_dev;
			next_s.sample_vld = 1'b1;
			if (s.act_bypass)
				next_s.sample = pol ? FDSC_FULL_SWING : -FDSC_FULL_SWING;
			else
				next_s.sample = acc <<< 1;
		end
	end

	// State register with fixed reset values
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.st <= FDSC_IDLE;
			s.dev_reg <= FDSC_RST_DEV;
			s.div_lo <= FDSC_RST_DIV_LO;
			s.upper <= FDSC_RST_UPPER;
			s.ctrl <= FDSC_RST_CTRL;
		end
		else
			s <= next_s;
	end

	// Deviation multiply and scale
	fdsc_scaler u_scaler
	(
		.clk(clk),
		.rst_n(rst_n),
		.sample(s.sample),
		.sample_vld(s.sample_vld),
		.cfg(s.sample_dev),
		.deviation(deviation),
		.deviation_vld(deviation_vld)
	);

	assign rdata = s.rdata;
	assign sample_tick = s.tick;
	assign active_divider = s.act_div;

	a_dev_write: assert property (@(posedge clk) disable iff (!rst_n)
		bus_req.wr && bus_req.addr == FDSC_OFS_DEV |=> s.dev_reg == $past(bus_req.wdata))
		else $error("deviation register not written");
	a_div_concat: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt == '0
		|=> active_divider == {$past(s.upper[2:0]), $past(s.div_lo)})
		else $error("divider not joined from both registers");
	a_cfg_stable: assert property (@(posedge clk) disable iff (!rst_n)
		!next_s.tick |=> $stable(s.act_dev) && $stable(s.act_div))
		else $error("setting changed between boundaries");
	a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
		sample_tick && active_divider == 11'h001 && s.ctrl[FDSC_CTRL_EN_BIT]
		&& prog_div == 11'h001 ##1 s.ctrl[FDSC_CTRL_EN_BIT] |=> sample_tick)
		else $error("divider spacing wrong");
	a_bypass_swing: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick && s.act_bypass && pol |=> s.sample == FDSC_FULL_SWING ##1 deviation_vld)
		else $error("bypass sample not full swing");
	a_invert_sign: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick && s.act_bypass && s.act_inv && chip_data |=> s.sample == -FDSC_FULL_SWING)
		else $error("inversion did not swap direction");

	// Register writes of the divider halves
	// check
	a_div_lo_write: assert property (@(posedge clk) disable iff (!rst_n)
		bus_req.wr && bus_req.addr == FDSC_OFS_DIV_LO |=> s.div_lo == $past(bus_req.wdata))
		else $error("divider low byte not written");
	a_upper_write: assert property (@(posedge clk) disable iff (!rst_n)
		bus_req.wr && bus_req.addr == FDSC_OFS_UPPER |=> s.upper == $past(bus_req.wdata))
		else $error("upper config not written");

	// Sample divider counting
	// check
	a_tick_load: assert property (@(posedge clk) disable iff (!rst_n)
		sample_tick |-> s.cnt == active_divider)
		else $error("counter not loaded with applied divider");
	a_count_down: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt != '0
		|=> !sample_tick && s.cnt == $past(s.cnt) - 1'b1)
		else $error("divider count step wrong");
	a_tick_due: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt == '0 |=> sample_tick)
		else $error("boundary missed at count end");
	a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_IDLE |=> !sample_tick && s.cnt == '0)
		else $error("boundary while idle");

	// Settings taken at the boundary
	// check
	a_ask_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt == '0
		&& s.ctrl[FDSC_CTRL_ASK_BIT] |=> s.act_bypass)
		else $error("shaping left on in ASK mode");
	a_bypass_load: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt == '0
		|=> s.act_bypass == $past(prog_bypass))
		else $error("bypass not taken at boundary");
	a_inv_load: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt == '0
		|=> s.act_inv == $past(s.ctrl[FDSC_CTRL_INV_BIT]))
		else $error("inversion not taken at boundary");
	a_dev_load: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == FDSC_RUN && s.ctrl[FDSC_CTRL_EN_BIT] && s.cnt == '0
		|=> s.act_dev == $past(s.dev_reg))
		else $error("deviation not taken at boundary");
	a_inv_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!next_s.tick |=> $stable(s.act_inv) && $stable(s.act_bypass))
		else $error("mode changed between boundaries");
	a_sample_dev: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick |=> s.sample_dev == $past(s.act_dev) && s.sample_vld)
		else $error("sample paired with wrong setting");

	// Filter output per history, status bypass bit and scaler valid
	// check
	a_bypass_low: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick && s.act_bypass && !pol |=> s.sample == -FDSC_FULL_SWING)
		else $error("bypass low sample not full swing");
	a_shaped_high: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick && !s.act_bypass && new_hist == '1 |=> s.sample == FDSC_FULL_SWING)
		else $error("settled high not full swing");
	a_shaped_low: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick && !s.act_bypass && new_hist == '0 |=> s.sample == -FDSC_FULL_SWING)
		else $error("settled low not full swing");
	a_shaped_mid: assert property (@(posedge clk) disable iff (!rst_n)
		s.tick && !s.act_bypass && new_hist == 4'h3 |=> s.sample == '0)
		else $error("mid step not at centre");
	a_status_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == FDSC_OFS_STATUS
		|=> rdata[FDSC_STAT_BYP_BIT] == $past(s.act_bypass))
		else $error("status bypass bit wrong");
	a_vld_follow: assert property (@(posedge clk) disable iff (!rst_n)
		s.sample_vld |=> deviation_vld)
		else $error("sample not scaled");

	c_shaped: cover property (@(posedge clk) s.tick && !s.act_bypass);
	c_ask: cover property (@(posedge clk) s.tick && s.ctrl[FDSC_CTRL_ASK_BIT]);
	c_stop: cover property (@(posedge clk) s.st == FDSC_RUN ##1 s.st == FDSC_IDLE);
	c_invert: cover property (@(posedge clk) s.tick && s.act_inv);

endmodule // fdsc_top

//--- fdsc_pkg.sv
package fdsc_pkg;

	// Register offsets
	localparam logic [7:0] FDSC_OFS_DEV = 8'h1c;
	localparam logic [7:0] FDSC_OFS_DIV_LO = 8'h1d;
	localparam logic [7:0] FDSC_OFS_UPPER = 8'h1e;
	localparam logic [7:0] FDSC_OFS_CTRL = 8'h20;
	localparam logic [7:0] FDSC_OFS_STATUS = 8'h21;

	// Reset values
	localparam logic [7:0] FDSC_RST_DEV = 8'hdf;
	localparam logic [7:0] FDSC_RST_DIV_LO = 8'h04;
	localparam logic [7:0] FDSC_RST_UPPER = 8'h78;
	localparam logic [7:0] FDSC_RST_CTRL = 8'h00;

	// Field positions
	localparam int FDSC_SCALE_LSB = 5;
	localparam int FDSC_BYPASS_BIT = 3;
	localparam int FDSC_UPPER_LSB = 0;
	localparam int FDSC_CTRL_EN_BIT = 0;
	localparam int FDSC_CTRL_INV_BIT = 1;
	localparam int FDSC_CTRL_ASK_BIT = 2;
	localparam int FDSC_STAT_RUN_BIT = 0;
	localparam int FDSC_STAT_BYP_BIT = 1;
	localparam int FDSC_STAT_INV_BIT = 2;

	// Widths
	localparam int FDSC_MULT_W = 5;
	localparam int FDSC_SCALE_W = 3;
	localparam int FDSC_UPPER_W = 3;
	localparam int FDSC_DIV_W = 11;
	localparam int FDSC_HIST_W = 4;
	localparam int FDSC_SAMPLE_W = 6;
	localparam int FDSC_PROD_W = 11;
	localparam int FDSC_DEV_W = 18;

	// Filter taps, one nibble per tap, oldest in the top nibble
	localparam logic [15:0] FDSC_TAPS = 16'h1331;
	// Unshaped full swing of one sample
	localparam logic signed [5:0] FDSC_FULL_SWING = 6'sh10;
	// Scaling codes of note
	localparam logic [2:0] FDSC_SCALE_DIV64 = 3'h0;
	localparam logic [2:0] FDSC_SCALE_UNITY = 3'h6;
	localparam logic [2:0] FDSC_SCALE_X2 = 3'h7;

	// Deviation setting as applied
	typedef struct packed
	{
		logic [FDSC_SCALE_W-1:0] scale_code;
		logic [FDSC_MULT_W-1:0] multiplier;
	} fdsc_dev_s;

	// Register port request
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fdsc_bus_s;

	typedef enum logic [1:0]
	{
		FDSC_IDLE = 2'b00,
		FDSC_RUN = 2'b01
	} fdsc_state_e;

endpackage

//--- fdsc_scaler.sv
module fdsc_scaler
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Shaped sample in
	input wire logic signed [fdsc_pkg::FDSC_SAMPLE_W-1:0] sample,
	input wire logic sample_vld,
	input wire fdsc_pkg::fdsc_dev_s cfg,
	// Deviation out, in units of 1/64 of a sample step
	output logic signed [fdsc_pkg::FDSC_DEV_W-1:0] deviation,
	output logic deviation_vld
);
	import fdsc_pkg::*;

	typedef struct packed
	{
		logic signed [FDSC_DEV_W-1:0] dev;
		logic vld;
	} fdsc_scl_s;

	fdsc_scl_s s;
	fdsc_scl_s next_s;
	logic signed [FDSC_PROD_W-1:0] prod;
	logic signed [FDSC_DEV_W-1:0] prod_ext;

	// Sample times unsigned multiplier
	// multiply by setting
	assign prod = FDSC_PROD_W'(sample * $signed({1'b0, cfg.multiplier}));
	assign prod_ext = FDSC_DEV_W'(prod);

	// Shift left by code: code 0 is x1/64, code 6 is x1, code 7 is x2
	always_comb
	begin
		next_s = s;
		next_s.vld = sample_vld;
		if (sample_vld)
			next_s.dev = prod_ext <<< cfg.scale_code;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign deviation = s.dev;
	assign deviation_vld = s.vld;

	a_scale_double: assert property (@(posedge clk) disable iff (!rst_n)
		sample_vld && cfg.scale_code == FDSC_SCALE_X2 |=> deviation == ($past(prod_ext) <<< 7))
		else $error("x2 scaling wrong");
	a_scale_unity: assert property (@(posedge clk) disable iff (!rst_n)
		sample_vld && cfg.scale_code == FDSC_SCALE_UNITY |=> deviation == ($past(prod_ext) <<< 6))
		else $error("unity scaling wrong");
	a_mult_zero: assert property (@(posedge clk) disable iff (!rst_n)
		sample_vld && cfg.multiplier == '0 |=> deviation == '0 && deviation_vld)
		else $error("zero multiplier gives nonzero deviation");
	a_dev_symmetric: assert property (@(posedge clk) disable iff (!rst_n)
		sample_vld && sample < 0 && cfg.multiplier != '0 |=> deviation < 0)
		else $error("deviation sign not centred");

	c_div64: cover property (@(posedge clk) sample_vld && cfg.scale_code == FDSC_SCALE_DIV64);

endmodule // fdsc_scaler

//--- tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fdsc_pkg::*;

	// Stimulus and observed signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	fdsc_bus_s bus_req = '0;
	logic chip_data = 1'b0;
	logic [7:0] rdata;
	logic sample_tick;
	logic [FDSC_DIV_W-1:0] active_divider;
	logic signed [FDSC_DEV_W-1:0] deviation;
	logic deviation_vld;
	logic signed [FDSC_DEV_W-1:0] seen [8];
	int err_count = 0;
	int checks = 0;
	int cycles = 0;

	fdsc_top dut
	(
		.clk(clk),
		.rst_n(rst_n),
		.bus_req(bus_req),
		.rdata(rdata),
		.chip_data(chip_data),
		.sample_tick(sample_tick),
		.active_divider(active_divider),
		.deviation(deviation),
		.deviation_vld(deviation_vld)
	);

	// Clock generation
	always #5 clk = ~clk;

	// Hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			err_count++;
			end_sim();
		end
	end

	// Verdict and end of run
	task end_sim;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Compare seen against expected
	task chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Register write, one strobe cycle
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask

	// Register read, data checked in the following cycle
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1;
		chk({10'h000, rdata}, {10'h000, exp});
	endtask

	// Wait for a tick or a deviation pulse, bounded
	task wait_ev(input logic vld, output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while ((vld ? deviation_vld : sample_tick) !== 1'b1 && n < 3000);
		if (n >= 3000)
			chk(18'h00001, 18'h00000);
	endtask

	// Reset values and unmapped read
	task t_reset;
		#1;
		chk(18'(active_divider), 18'h00000);
		chk(deviation, 18'h00000);
		rd_chk(FDSC_OFS_DEV, 8'hdf);
		rd_chk(FDSC_OFS_DIV_LO, 8'h04);
		rd_chk(FDSC_OFS_UPPER, 8'h78);
		rd_chk(8'h40, 8'h00);
	endtask

	// Divider halves joined and applied only at a boundary
	task t_divider;
		int n;
		int m;
		wr(FDSC_OFS_DIV_LO, 8'h03);
		wr(FDSC_OFS_CTRL, 8'h01);
		repeat (2) wait_ev(1'b0, n);
		chk(18'(active_divider), 18'h00003);
		wait_ev(1'b0, n);
		chk(18'(n), 18'd4);
		wr(FDSC_OFS_UPPER, 8'h79);
		#1;
		chk(18'(active_divider), 18'h00003);
		wait_ev(1'b0, n);
		chk(18'(active_divider), 18'h00103);
		wait_ev(1'b0, n);
		chk(18'(n), 18'd260);
		wr(FDSC_OFS_UPPER, 8'h78);
		repeat (2) wait_ev(1'b0, n);
		// divider fifteen, sixteen steps span a 256 cycle chip
		wr(FDSC_OFS_DIV_LO, 8'h0f);
		repeat (2) wait_ev(1'b0, n);
		m = 0;
		repeat (16)
		begin
			wait_ev(1'b0, n);
			m += n;
		end
		chk(18'(m), 18'd256);
		// Shortest useful divider
		wr(FDSC_OFS_DIV_LO, 8'h01);
		repeat (2) wait_ev(1'b0, n);
		wait_ev(1'b0, n);
		chk(18'(n), 18'd2);
		wr(FDSC_OFS_DIV_LO, 8'h03);
		repeat (2) wait_ev(1'b0, n);
	endtask

	// Every scaling code, plus multiplier bounds
	task t_scale;
		int n;
		logic [2:0] code;
		logic [4:0] mult;
		@(posedge clk);
		chip_data <= 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			code = (i < 8) ? 3'(i) : 3'h6;
			mult = (i < 8) ? 5'h1f : ((i == 8) ? 5'h00 : ((i == 9) ? 5'h01 : 5'h10));
			wr(FDSC_OFS_DEV, {code, mult});
			repeat (2) wait_ev(1'b0, n);
			wait_ev(1'b1, n);
			chk(deviation, (18'sd16 * 18'(mult)) <<< code);
		end
	endtask

	// Direction versus chip value and inversion
	task t_invert;
		int n;
		wr(FDSC_OFS_DEV, 8'hc1);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			chip_data <= i[0];
			wr(FDSC_OFS_CTRL, {6'h00, i[1], 1'b1});
			repeat (2) wait_ev(1'b0, n);
			wait_ev(1'b1, n);
			chk(deviation, (i[0] ^ i[1]) ? 18'sd1024 : -18'sd1024);
		end
	endtask

	// Shaped step, or unshaped step when ASK forces bypass
	task t_shape(input logic ask);
		int n;
		int k;
		k = -1;
		wr(FDSC_OFS_UPPER, 8'h70);
		wr(FDSC_OFS_CTRL, {5'h00, ask, 2'b01});
		@(posedge clk);
		chip_data <= 1'b0;
		repeat (6) wait_ev(1'b0, n);
		@(posedge clk);
		chip_data <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			wait_ev(1'b1, n);
			seen[i] = deviation;
		end
		for (int i = 0; i < 6; i++)
			if (seen[i] === -18'sd768 && k < 0)
				k = i;
		if (ask)
			chk(18'(k), 18'h3ffff);
		else
		begin
			chk(seen[k+1], 18'sd0);
			chk(seen[k+2], 18'sd768);
		end
		chk(seen[7], 18'sd1024);
		rd_chk(FDSC_OFS_STATUS, {6'h00, ask, 1'b1});
	endtask

	// Reset in mid-run returns to idle and reset values
	task t_rerun;
		int n;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(18'(active_divider), 18'h00000);
		chk({17'h00000, sample_tick}, 18'h00000);
		rd_chk(FDSC_OFS_UPPER, 8'h78);
		rd_chk(FDSC_OFS_DEV, 8'hdf);
		wr(FDSC_OFS_CTRL, 8'h01);
		wait_ev(1'b0, n);
		chk(18'(active_divider), 18'h00004);
	endtask

	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_divider();
		t_scale();
		t_invert();
		t_shape(1'b0);
		t_shape(1'b1);
		t_rerun();
		end_sim();
	end

endmodule // tb_top
